/* pkg/tws_pkg.sv */
// Purpose: shared constants and types for the 3-wire serial config link
// Assumes: pclk at 10 MHz; both ends use the same frame layout
// Notes:   frame = rw flag, 15-bit address, then 8-bit data bytes, msb first
package tws_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 100;
  // controller-made serial clock; slow enough for two synchronisers per hop
  localparam int unsigned SCLK_PERIOD_NS = 1600;
  localparam int unsigned SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  localparam int unsigned ADDR_BITS  = 16;
  localparam int unsigned RADDR_W    = 15;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned MAX_BYTES  = 4;
  localparam int unsigned FRAME_W    = ADDR_BITS + BYTE_W * MAX_BYTES;

  // device register map
  localparam logic [14:0] A_CFG_LAST  = 15'h0002;
  localparam logic [14:0] A_ID_FIRST  = 15'h0003;
  localparam logic [14:0] A_ID_LAST   = 15'h0005;
  localparam logic [14:0] A_FUNC_FST  = 15'h0020;
  localparam logic [14:0] A_FUNC_LST  = 15'h0026;
  localparam logic [14:0] A_FWD_GAIN  = 15'h0023;
  localparam logic [14:0] A_REV_GAIN  = 15'h0024;
  localparam logic [14:0] A_IF_BW     = 15'h0025;
  localparam int unsigned REG_DEPTH   = 39;
  localparam int unsigned COARSE_LSB  = 0;
  localparam int unsigned FINE_LSB    = 4;
  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [7:0]  GAIN_STEP   = 8'h06;

  // controller apb register map
  localparam logic [7:0] C_CTRL   = 8'h00;
  localparam logic [7:0] C_ADDR   = 8'h04;
  localparam logic [7:0] C_LEN    = 8'h08;
  localparam logic [7:0] C_WDATA  = 8'h0c;
  localparam logic [7:0] C_RDATA  = 8'h10;
  localparam logic [7:0] C_STATUS = 8'h14;
  localparam int unsigned CTRL_GO   = 0;
  localparam int unsigned CTRL_READ = 1;
  localparam int unsigned ST_BUSY   = 0;
  localparam int unsigned ST_DONE   = 1;

  typedef enum logic [2:0] {
    TGT_IDLE = 3'b001,
    TGT_ADDR = 3'b010,
    TGT_DATA = 3'b100
  } tws_tgt_e;

  typedef enum logic [2:0] {
    CT_IDLE  = 3'b001,
    CT_SHIFT = 3'b010,
    CT_TAIL  = 3'b100
  } tws_ctl_e;
endpackage : tws_pkg

/* pkg/tws_link_if.sv */
// Purpose: wires between serial controller and target
// Assumes: at most one end enables its data driver at a time
// Notes:   the shared data line idles low when nobody drives it
`timescale 1ns/1ps
interface tws_link_if;
  logic cs_n;
  logic sclk;
  logic ctl_o;
  logic ctl_oe;
  logic tgt_o;
  logic tgt_oe;
  logic sdio;

  assign sdio = tgt_oe ? tgt_o : (ctl_oe ? ctl_o : 1'b0);

  modport ctrl (output cs_n, output sclk, output ctl_o, output ctl_oe, input sdio);
  modport tgt  (input cs_n, input sclk, input sdio, output tgt_o, output tgt_oe);
endinterface : tws_link_if

/* verilog/tws_sync.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are slow levels relative to pclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module tws_sync #(
  parameter int unsigned W        = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // pins in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end
endmodule : tws_sync

/* verilog/tws_target.sv */
// Purpose: 3-wire serial target holding the if path configuration registers
// Assumes: sclk, cs_n and sdio are pins; pclk is much faster than sclk
// Notes:   pins pass a two-flop synchroniser before any logic reads them
//
// Overview of operation
// - one shared data line, 16-bit address, 8-bit registers
// - address then data bytes, msb first
// - top address bit: 0 write, 1 read
// - cs_n falling starts, rising ends a transaction
// - sample data on sclk rise while selected
// - drive data within half cycle after address
// - release data line when cs_n goes high
// - single and streaming reads and writes
// - streaming bytes step address down by one
// - config/id at 0x00-0x05, functions 0x20-0x26
// - 0x25 coarse bandwidth code 0..15
// - 0x25 fine bandwidth code 0..15
// - one bandwidth pair for both channels
// - forward gain 0x23, reverse gain 0x24
// - gain in db is code floored to six
// - codes above 48 db still apply
// - port ignores pins while cs_n high
`timescale 1ns/1ps
module tws_target
  import tws_pkg::*;
#(
  // identification bytes at 0x03..0x05; value is arbitrary
  parameter logic [23:0] ID_CODE = 24'h3c_a5_5a
) (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // serial link
  tws_link_if.tgt         link,
  // if path controls
  output logic      [3:0] if_coarse_bw_code,
  output logic      [3:0] if_fine_bw_code,
  output logic      [7:0] forward_gain_code,
  output logic      [7:0] reverse_gain_code,
  output logic      [7:0] forward_gain_db,
  output logic      [7:0] reverse_gain_db
);
  logic [2:0] pins;
  logic       s_cs_n;
  logic       s_sclk;
  logic       s_sdio;
  logic       sclk_prev;
  logic       rise;
  logic       fall;

  tws_sync #(
    .W       (3),
    .RST_VAL (3'b100)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({link.cs_n, link.sclk, link.sdio}),
    .q       (pins)
  );

  assign s_cs_n = pins[2];
  assign s_sclk = pins[1];
  assign s_sdio = pins[0];
  assign rise   = s_sclk & ~sclk_prev;
  assign fall   = ~s_sclk & sclk_prev;

  tws_tgt_e    state;
  logic [3:0]  cnt;
  logic [14:0] sh;
  logic [14:0] addr;
  logic        rd;
  logic [7:0]  tx;
  logic        sdo;
  logic        oe;
  logic        pend;
  logic [7:0]  regs [REG_DEPTH];

  tws_tgt_e    next_state;
  logic [3:0]  next_cnt;
  logic [14:0] next_sh;
  logic [14:0] next_addr;
  logic        next_rd;
  logic [7:0]  next_tx;
  logic        next_sdo;
  logic        next_oe;
  logic        next_pend;
  logic [7:0]  next_regs [REG_DEPTH];

  function automatic logic writable(input logic [14:0] a);
    writable = (a <= A_CFG_LAST) || (a >= A_FUNC_FST && a <= A_FUNC_LST);
  endfunction : writable

  // unmapped addresses read zero; id bytes are constants
  function automatic logic [7:0] rd_byte(input logic [14:0] a);
    logic [7:0] v;
    logic [1:0] k;
    v = 8'h00;
    // 0x03, 0x04, 0x05 pick id bytes 0, 1, 2
    k = a[1:0] + 2'd1;
    if (a >= A_ID_FIRST && a <= A_ID_LAST) begin
      v = ID_CODE[8*k +: 8];
    end else if (writable(a)) begin
      v = regs[a[5:0]];
    end
    rd_byte = v;
  endfunction : rd_byte

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_sh    = sh;
    next_addr  = addr;
    next_rd    = rd;
    next_tx    = tx;
    next_sdo   = sdo;
    next_oe    = oe;
    next_pend  = pend;
    for (int i = 0; i < REG_DEPTH; i++) begin
      next_regs[i] = regs[i];
    end
    if (s_cs_n) begin
      // deselected: forget any partial frame and let go of the line
      next_state = TGT_IDLE;
      next_cnt   = 4'h0;
      next_oe    = 1'b0;
      next_pend  = 1'b0;
    end else begin
      unique case (state)
        TGT_IDLE: begin
          next_state = TGT_ADDR;
          next_cnt   = 4'h0;
        end
        TGT_ADDR: begin
          if (rise) begin
            next_sh  = {sh[13:0], s_sdio};
            next_cnt = cnt + 4'h1;
            if (cnt == 4'(ADDR_BITS - 1)) begin
              next_state = TGT_DATA;
              next_cnt   = 4'h0;
              next_addr  = {sh[13:0], s_sdio};
              next_rd    = sh[14];
              if (sh[14]) begin
                // first data bit goes out well before the next falling edge
                next_tx  = rd_byte({sh[13:0], s_sdio});
                next_sdo = next_tx[7];
                next_oe  = 1'b1;
              end
            end
          end
        end
        TGT_DATA: begin
          if (rise) begin
            next_cnt = cnt + 4'h1;
            if (!rd) begin
              next_tx = {tx[6:0], s_sdio};
            end
            if (cnt == 4'(BYTE_W - 1)) begin
              next_cnt  = 4'h0;
              next_addr = addr - 15'h0001;
              if (!rd) begin
                if (writable(addr)) begin
                  next_regs[addr[5:0]] = {tx[6:0], s_sdio};
                end
              end else begin
                next_pend = 1'b1;
              end
            end
          end else if (fall && rd) begin
            if (pend) begin
              next_tx   = rd_byte(addr);
              next_sdo  = next_tx[7];
              next_pend = 1'b0;
            end else if (cnt != 4'h0) begin
              // the fall closing the last address bit keeps bit 7 out
              next_tx  = {tx[6:0], 1'b0};
              next_sdo = tx[6];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= TGT_IDLE;
      cnt       <= 4'h0;
      sh        <= 15'h0000;
      addr      <= 15'h0000;
      rd        <= 1'b0;
      tx        <= 8'h00;
      sdo       <= 1'b0;
      oe        <= 1'b0;
      pend      <= 1'b0;
      sclk_prev <= 1'b0;
      for (int i = 0; i < REG_DEPTH; i++) begin
        regs[i] <= REG_RESET;
      end
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      sh        <= next_sh;
      addr      <= next_addr;
      rd        <= next_rd;
      tx        <= next_tx;
      sdo       <= next_sdo;
      oe        <= next_oe;
      pend      <= next_pend;
      sclk_prev <= s_sclk;
      for (int i = 0; i < REG_DEPTH; i++) begin
        regs[i] <= next_regs[i];
      end
    end
  end

  assign link.tgt_o  = sdo;
  assign link.tgt_oe = oe;

  // control outputs; gain in db lags its register by one cycle
  logic [7:0] next_fwd_db;
  logic [7:0] next_rev_db;

  always_comb begin
    next_fwd_db = regs[A_FWD_GAIN[5:0]] - (regs[A_FWD_GAIN[5:0]] % GAIN_STEP);
    next_rev_db = regs[A_REV_GAIN[5:0]] - (regs[A_REV_GAIN[5:0]] % GAIN_STEP);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      forward_gain_db <= 8'h00;
      reverse_gain_db <= 8'h00;
    end else begin
      forward_gain_db <= next_fwd_db;
      reverse_gain_db <= next_rev_db;
    end
  end

  // one bandwidth pair serves both channels
  assign if_coarse_bw_code = regs[A_IF_BW[5:0]][COARSE_LSB +: 4];
  assign if_fine_bw_code   = regs[A_IF_BW[5:0]][FINE_LSB +: 4];
  assign forward_gain_code = regs[A_FWD_GAIN[5:0]];
  assign reverse_gain_code = regs[A_REV_GAIN[5:0]];
endmodule : tws_target

/* verilog/tws_ctrl.sv */
// Purpose: apb-programmed controller end of the 3-wire serial link
// Assumes: software waits for busy low before starting a new frame
// Notes:   makes sclk by dividing pclk; data samples at sclk falling edge
`timescale 1ns/1ps
module tws_ctrl
  import tws_pkg::*;
#(
  parameter int unsigned HALF_CYC = SCLK_HALF_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial link
  tws_link_if.ctrl         link
);
  logic s_sdio;

  tws_sync #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (link.sdio),
    .q       (s_sdio)
  );

  tws_ctl_e     state;
  logic [7:0]   div;
  logic         sclk;
  logic         cs_n;
  logic         so;
  logic         soe;
  logic [47:0]  tx;
  logic [5:0]   bidx;
  logic [5:0]   total;
  logic [31:0]  rx;
  logic         c_read;
  logic [14:0]  c_addr;
  logic [2:0]   c_len;
  logic [31:0]  c_wdata;
  logic [31:0]  c_rdata;
  logic         done;

  tws_ctl_e     next_state;
  logic [7:0]   next_div;
  logic         next_sclk;
  logic         next_cs_n;
  logic         next_so;
  logic         next_soe;
  logic [47:0]  next_tx;
  logic [5:0]   next_bidx;
  logic [5:0]   next_total;
  logic [31:0]  next_rx;
  logic         next_c_read;
  logic [14:0]  next_c_addr;
  logic [2:0]   next_c_len;
  logic [31:0]  next_c_wdata;
  logic [31:0]  next_c_rdata;
  logic         next_done;
  logic [31:0]  next_prdata;
  logic         next_pready;
  logic         next_pslverr;

  logic setup;
  logic wr_acc;
  logic tick;
  logic mapped;

  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite;
  assign tick   = (div == 8'(HALF_CYC - 1));
  assign mapped = (paddr == C_CTRL) || (paddr == C_ADDR) || (paddr == C_LEN) ||
                  (paddr == C_WDATA) || (paddr == C_RDATA) || (paddr == C_STATUS);

  always_comb begin
    next_state   = state;
    next_div     = tick ? 8'h00 : div + 8'h01;
    next_sclk    = sclk;
    next_cs_n    = cs_n;
    next_so      = so;
    next_soe     = soe;
    next_tx      = tx;
    next_bidx    = bidx;
    next_total   = total;
    next_rx      = rx;
    next_c_read  = c_read;
    next_c_addr  = c_addr;
    next_c_len   = c_len;
    next_c_wdata = c_wdata;
    next_c_rdata = c_rdata;
    next_done    = done;
    next_pready  = setup;
    next_pslverr = setup & ~mapped;
    next_prdata  = prdata;
    if (setup) begin
      unique case (paddr)
        C_CTRL:   next_prdata = {30'h0, c_read, 1'b0};
        C_ADDR:   next_prdata = {17'h0, c_addr};
        C_LEN:    next_prdata = {29'h0, c_len};
        C_WDATA:  next_prdata = c_wdata;
        C_RDATA:  next_prdata = c_rdata;
        C_STATUS: next_prdata = {30'h0, done, state != CT_IDLE};
        default:  next_prdata = 32'h0;
      endcase
    end
    if (wr_acc) begin
      unique case (paddr)
        C_ADDR:   next_c_addr  = pwdata[14:0];
        C_LEN:    next_c_len   = (pwdata[2:0] == 3'd0) ? 3'd1 :
                                 (pwdata[2:0] > 3'd4) ? 3'd4 : pwdata[2:0];
        C_WDATA:  next_c_wdata = pwdata;
        C_STATUS: next_done    = done & ~pwdata[ST_DONE];
        default:  next_c_read  = next_c_read;
      endcase
      if (paddr == C_CTRL && state == CT_IDLE) begin
        next_c_read = pwdata[CTRL_READ];
      end
    end
    unique case (state)
      CT_IDLE: begin
        if (wr_acc && paddr == C_CTRL && pwdata[CTRL_GO]) begin
          // frame: rw, address, data bytes msb first from bit 8*len-1
          next_tx    = {pwdata[CTRL_READ], c_addr,
                        c_wdata << {3'd4 - c_len, 3'b000}};
          next_so    = pwdata[CTRL_READ];
          next_soe   = 1'b1;
          next_cs_n  = 1'b0;
          next_sclk  = 1'b0;
          next_div   = 8'h00;
          next_bidx  = 6'h00;
          next_total = 6'(ADDR_BITS) + {c_len, 3'b000};
          next_rx    = 32'h0;
          next_state = CT_SHIFT;
        end
      end
      CT_SHIFT: begin
        // hold the last address bit one cycle past its rise so the
        // target's synchroniser takes it, then let go before it drives
        if (sclk && div == 8'h00 && c_read && bidx == 6'(ADDR_BITS - 1)) begin
          next_soe = 1'b0;
        end
        if (tick && !sclk) begin
          next_sclk = 1'b1;
        end else if (tick) begin
          next_sclk = 1'b0;
          if (c_read && bidx >= 6'(ADDR_BITS)) begin
            next_rx = {rx[30:0], s_sdio};
          end
          if (bidx == total - 6'h01) begin
            next_state = CT_TAIL;
          end else begin
            next_bidx = bidx + 6'h01;
            next_tx   = {tx[46:0], 1'b0};
            next_so   = tx[46];
          end
        end
      end
      CT_TAIL: begin
        if (tick) begin
          next_cs_n  = 1'b1;
          next_soe   = 1'b0;
          next_done  = 1'b1;
          next_state = CT_IDLE;
          if (c_read) begin
            next_c_rdata = rx;
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= CT_IDLE;
      div     <= 8'h00;
      sclk    <= 1'b0;
      cs_n    <= 1'b1;
      so      <= 1'b0;
      soe     <= 1'b0;
      tx      <= 48'h0;
      bidx    <= 6'h00;
      total   <= 6'h00;
      rx      <= 32'h0;
      c_read  <= 1'b0;
      c_addr  <= 15'h0000;
      c_len   <= 3'd1;
      c_wdata <= 32'h0;
      c_rdata <= 32'h0;
      done    <= 1'b0;
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      state   <= next_state;
      div     <= next_div;
      sclk    <= next_sclk;
      cs_n    <= next_cs_n;
      so      <= next_so;
      soe     <= next_soe;
      tx      <= next_tx;
      bidx    <= next_bidx;
      total   <= next_total;
      rx      <= next_rx;
      c_read  <= next_c_read;
      c_addr  <= next_c_addr;
      c_len   <= next_c_len;
      c_wdata <= next_c_wdata;
      c_rdata <= next_c_rdata;
      done    <= next_done;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  assign link.cs_n   = cs_n;
  assign link.sclk   = sclk;
  assign link.ctl_o  = so;
  assign link.ctl_oe = soe;
endmodule : tws_ctrl

/* bench/tws_link_checker.sv */
// Purpose: timing and ownership checks on the 3-wire link wires
// Assumes: controller built with an sclk half period of 8 pclk
// Notes:   sees only interface signals; the bench instantiates it
`timescale 1ns/1ps
module tws_link_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic ctl_o,
  input wire logic ctl_oe,
  input wire logic tgt_o,
  input wire logic tgt_oe,
  input wire logic sdio
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // one sclk phase is eight pclk cycles
  sequence s_half_low;
    !sclk [*8];
  endsequence
  sequence s_half_high;
    sclk [*8];
  endsequence

  chk_one_driver: assert property (!(tgt_oe && ctl_oe))
    else $error("both ends drive the data line");
  chk_line_owner: assert property (tgt_oe |-> sdio == tgt_o)
    else $error("data line does not carry the target bit");
  chk_frame_lead: assert property ($fell(cs_n) |-> s_half_low)
    else $error("sclk not low for a half period after select");
  chk_frame_end: assert property ($rose(cs_n) |-> !sclk && !ctl_oe)
    else $error("frame ended with sclk high or controller driving");
  chk_sclk_high: assert property ($rose(sclk) |-> s_half_high)
    else $error("sclk high phase too short");
  chk_hold_data: assert property (ctl_oe && sclk && $past(sclk) |-> $stable(ctl_o))
    else $error("controller data moved while sclk high");
  chk_turn_around: assert property ($fell(ctl_oe) && !cs_n |-> ##[1:7] tgt_oe)
    else $error("target late taking the data line");
  chk_drive_start: assert property ($rose(tgt_oe) |-> sclk && !cs_n)
    else $error("target started driving outside the high phase");
  chk_line_release: assert property ($rose(cs_n) |-> ##[1:5] !tgt_oe)
    else $error("target kept the data line after deselect");
  chk_quiet_idle: assert property (cs_n && !tgt_oe |=> !tgt_oe)
    else $error("target drove while deselected");
  chk_sclk_idle: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("sclk toggled while deselected");
endmodule : tws_link_checker

/* bench/three_wire_spi_if_path_config_tb.sv */
// Purpose: end-to-end bench, apb controller talking to the config target
// Assumes: zero-wait apb slave; frames polled through the status register
// Notes:   a wire monitor rebuilds every frame from sdio at sclk rises
`timescale 1ns/1ps
module three_wire_spi_if_path_config_tb;
  import tws_pkg::*;
  // id value is arbitrary
  localparam logic [23:0] ID_VAL = 24'h3c_a5_5a;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  if_coarse_bw_code;
  logic [3:0]  if_fine_bw_code;
  logic [7:0]  forward_gain_code;
  logic [7:0]  reverse_gain_code;
  logic [7:0]  forward_gain_db;
  logic [7:0]  reverse_gain_db;
  logic [47:0] wire_bits;
  int          wire_n;
  int          fails;
  int          check_count;
  int          cyc;

  tws_link_if link();
  tws_ctrl #(.HALF_CYC(8)) i_tws_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  tws_target #(.ID_CODE(ID_VAL)) i_tws_target (.pclk(pclk), .presetn(presetn),
    .link(link), .if_coarse_bw_code(if_coarse_bw_code), .if_fine_bw_code(if_fine_bw_code),
    .forward_gain_code(forward_gain_code), .reverse_gain_code(reverse_gain_code),
    .forward_gain_db(forward_gain_db), .reverse_gain_db(reverse_gain_db));
  tws_link_checker i_tws_link_checker (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n),
    .sclk(link.sclk), .ctl_o(link.ctl_o), .ctl_oe(link.ctl_oe), .tgt_o(link.tgt_o),
    .tgt_oe(link.tgt_oe), .sdio(link.sdio));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // wire monitor: both ends' bits as the target sees them
  always @(posedge link.sclk) begin
    if (link.cs_n === 1'b0) begin
      wire_bits = {wire_bits[46:0], link.sdio};
      wire_n = wire_n + 1;
    end
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails = fails + 1;
      final_report();
    end
  end

  function automatic logic [7:0] db_of(input logic [7:0] code);
    return code - (code % 8'h06);
  endfunction : db_of

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // d is write data, or the expected read data with unused bits zero
  task automatic frame(input logic rd, input logic [14:0] a, input int len,
                       input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    logic [47:0] m;
    int          n;
    apb(1'b1, C_ADDR, {17'h0, a}, q, e);
    apb(1'b1, C_LEN, 32'(len), q, e);
    apb(1'b1, C_WDATA, d, q, e);
    wire_n = 0;
    apb(1'b1, C_CTRL, {30'h0, rd, 1'b1}, q, e);
    n = 0;
    q = '0;
    while (q[ST_DONE] !== 1'b1 && n < 2000) begin
      apb(1'b0, C_STATUS, 32'h0, q, e);
      n = n + 1;
    end
    chk(48'(q[ST_DONE]), 48'h1);
    apb(1'b1, C_STATUS, 32'h2, q, e);
    m = (48'h1 << (16 + 8 * len)) - 48'h1;
    chk(48'(wire_n), 48'(16 + 8 * len));
    chk(wire_bits & m, ((48'({rd, a}) << (8 * len)) | 48'(d)) & m);
    if (rd) begin
      apb(1'b0, C_RDATA, 32'h0, q, e);
      chk(48'(q), 48'(d) & m);
    end
  endtask : frame

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    logic [7:0]  fg;
    logic [7:0]  rv;
    logic [7:0]  bw;
    logic [23:0] cf;
    logic [31:0] q;
    logic        e;
    logic [7:0]  corner [4];
    corner = '{8'h05, 8'h30, 8'h35, 8'hff};
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wire_bits = '0;
    wire_n = 0;
    fails = 0;
    check_count = 0;
    cyc = 0;
    q = $urandom(32'hb009);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(48'({if_fine_bw_code, if_coarse_bw_code, forward_gain_code, reverse_gain_code}),
        48'h0);
    frame(1'b1, A_FWD_GAIN, 1, 32'h0);
    $display("test reset done");
    // corner gain codes first: floor edges and codes above 48 db
    for (int i = 0; i < 6; i++) begin
      fg = (i < 4) ? corner[i] : 8'($urandom);
      rv = 8'($urandom);
      bw = 8'($urandom);
      frame(1'b0, A_IF_BW, 3, {8'h00, bw, rv, fg});
      chk(48'({if_fine_bw_code, if_coarse_bw_code}), 48'(bw));
      chk(48'(if_coarse_bw_code), 48'(bw[3:0]));
      chk(48'({forward_gain_code, reverse_gain_code}), 48'({fg, rv}));
      chk(48'(forward_gain_db), 48'(db_of(fg)));
      chk(48'(reverse_gain_db), 48'(db_of(rv)));
      frame(1'b1, A_FUNC_LST, 4, {8'h00, bw, rv, fg});
    end
    $display("test gain and bandwidth done");
    frame(1'b1, A_ID_LAST, 3, {8'h00, ID_VAL});
    frame(1'b0, 15'h0004, 1, 32'h33);
    frame(1'b1, 15'h0004, 1, {24'h0, ID_VAL[15:8]});
    frame(1'b0, 15'h0010, 1, 32'hff);
    frame(1'b1, 15'h0011, 2, 32'h0);
    $display("test id and unused done");
    cf = 24'($urandom);
    frame(1'b0, A_CFG_LAST, 3, {8'h00, cf});
    frame(1'b1, A_CFG_LAST, 3, {8'h00, cf});
    // streaming down from 0x0000 wraps into the unused top address
    frame(1'b1, 15'h0000, 2, {16'h0, cf[7:0], 8'h00});
    $display("test config and wrap done");
    apb(1'b0, 8'h18, 32'h0, q, e);
    chk(48'(e), 48'h1);
    chk(48'(q), 48'h0);
    $display("test apb unmapped done");
    final_report();
  end
endmodule : three_wire_spi_if_path_config_tb
